//--- hdl/alt_an_lt_ctrl.sv
// How it works
// - each ability bit set advertises that protocol in the link codeword
// - training off keeps every lane in normal mission mode
// - a restart sends training back to its start from any state while training is on
// - preset bits go into the control block of outgoing frames
// - initialize bits go into the control block of outgoing frames
// - lane 0 seed is loaded as pattern generator start state
// - lane 0 post-tap update goes into the control block field
// - lane 0 main-tap update goes into the control block field
// - lane 0 pre-tap update goes into the control block field
// - lane 0 post-tap report goes into the status block field
// - lane 0 main-tap report goes into the status block field
// - the settings come from registers since the bus is used
`timescale 1ns/1ps
`default_nettype none
module alt_an_lt_ctrl
  import alt_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [ADR_W-1:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [DAT_W-1:0] WB_DAT_I,
  output logic [DAT_W-1:0] WB_DAT_O,
  output logic WB_ACK_O,
  output logic [NUM_ABILITY-1:0] TX_ABILITY,
  output alt_ctrl_blk_s TX_CTRL_BLK,
  output alt_stat_blk_s TX_STAT_BLK,
  output logic [NUM_LANES-1:0] LANE_TRAINING,
  output logic LANE0_PATTERN
);

  // ******************************************************
  // reset release
  // ******************************************************
  logic [1:0] rst_q;
  logic rst_n;

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_q <= 2'b00;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end

  assign rst_n = rst_q[1];

  // ******************************************************
  // state
  // ******************************************************
  typedef struct packed {
    logic ack;
    logic [DAT_W-1:0] rdata;
    logic [NUM_ABILITY-1:0] ability;
    logic train_on;
    logic redo;
    logic [NUM_LANES-1:0] rx_equalizer_done;
    alt_ctrl_blk_s ctrl;
    logic [SEED_W-1:0] lane0_pattern_seed;
    logic [1:0] lane0_post_tap_report;
    logic [1:0] lane0_main_tap_report;
    alt_train_e fsm;
    logic [NUM_ABILITY-1:0] tx_ability;
    alt_ctrl_blk_s tx_ctrl;
    alt_stat_blk_s tx_stat;
    logic [NUM_LANES-1:0] lane_training;
  } alt_top_s;

  alt_top_s s;
  alt_top_s next_s;
  logic pattern_bit;
  logic bus_req;
  logic bus_wr;

  // byte-lane merge of a write into the old word
  function automatic logic [DAT_W-1:0] merge(
    input logic [DAT_W-1:0] old,
    input logic [DAT_W-1:0] wd,
    input logic [3:0] sel
  );
    logic [DAT_W-1:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  assign bus_req = WB_CYC_I && WB_STB_I;
  // a write lands at the edge where the master sees ack
  assign bus_wr = bus_req && WB_WE_I && s.ack;

  // ******************************************************
  // next state
  // ******************************************************
  always_comb begin
    logic [DAT_W-1:0] w;
    w = '0;
    next_s = s;
    next_s.redo = 1'b0;
    next_s.ack = bus_req && !s.ack;

    if (bus_req && !s.ack) begin
      case (WB_ADR_I)
        ADR_ABILITY: begin
          next_s.rdata = DAT_W'(s.ability);
        end
        ADR_TRAIN_CTRL: begin
          next_s.rdata = DAT_W'(s.train_on);
        end
        ADR_LANE_FLAGS: begin
          next_s.rdata = DAT_W'({s.ctrl.init, s.ctrl.preset,
                                 s.rx_equalizer_done});
        end
        ADR_LANE0_SEED: begin
          next_s.rdata = DAT_W'(s.lane0_pattern_seed);
        end
        ADR_LANE0_COEF: begin
          next_s.rdata = DAT_W'({s.lane0_main_tap_report,
                                 s.lane0_post_tap_report, s.ctrl.pre_upd,
                                 s.ctrl.main_upd, s.ctrl.post_upd});
        end
        ADR_TRAIN_STATUS: begin
          next_s.rdata = DAT_W'({pattern_bit, s.lane_training, s.fsm});
        end
        default: begin
          // unmapped offsets answer with zero
          next_s.rdata = '0;
        end
      endcase
    end

    if (bus_wr) begin
      case (WB_ADR_I)
        ADR_ABILITY: begin
          w = merge(DAT_W'(s.ability), WB_DAT_I, WB_SEL_I);
          next_s.ability = w[NUM_ABILITY-1:0];
        end
        ADR_TRAIN_CTRL: begin
          w = merge(DAT_W'(s.train_on), WB_DAT_I, WB_SEL_I);
          next_s.train_on = w[FLD_TRAIN_ON];
          // restart is a write-one pulse and reads back zero
          next_s.redo = w[FLD_TRAIN_REDO];
        end
        ADR_LANE_FLAGS: begin
          w = merge(DAT_W'({s.ctrl.init, s.ctrl.preset,
                            s.rx_equalizer_done}), WB_DAT_I, WB_SEL_I);
          next_s.rx_equalizer_done = w[FLD_RX_DONE_LSB +: NUM_LANES];
          next_s.ctrl.preset = w[FLD_PRESET_LSB +: NUM_LANES];
          next_s.ctrl.init = w[FLD_INIT_LSB +: NUM_LANES];
        end
        ADR_LANE0_SEED: begin
          w = merge(DAT_W'(s.lane0_pattern_seed), WB_DAT_I, WB_SEL_I);
          next_s.lane0_pattern_seed = w[SEED_W-1:0];
        end
        ADR_LANE0_COEF: begin
          w = merge(DAT_W'({s.lane0_main_tap_report,
                            s.lane0_post_tap_report, s.ctrl.pre_upd,
                            s.ctrl.main_upd, s.ctrl.post_upd}),
                    WB_DAT_I, WB_SEL_I);
          next_s.ctrl.post_upd = w[FLD_POST_UPD_LSB +: 2];
          next_s.ctrl.main_upd = w[FLD_MAIN_UPD_LSB +: 2];
          next_s.ctrl.pre_upd = w[FLD_PRE_UPD_LSB +: 2];
          next_s.lane0_post_tap_report = w[FLD_POST_RPT_LSB +: 2];
          next_s.lane0_main_tap_report = w[FLD_MAIN_RPT_LSB +: 2];
        end
        default: begin
          // read-only and unmapped offsets ignore writes
          next_s.rdata = next_s.rdata;
        end
      endcase
    end

    // training sequencer
    case (s.fsm)
      ST_OFF: begin
        if (s.train_on) begin
          next_s.fsm = ST_LOAD;
        end
      end
      ST_LOAD: begin
        next_s.fsm = ST_RUN;
      end
      ST_RUN: begin
        // receiver-trained flags end the receive part
        if (&s.rx_equalizer_done) begin
          next_s.fsm = ST_DONE;
        end
      end
      ST_DONE: begin
        next_s.fsm = ST_DONE;
      end
      default: begin
        next_s.fsm = ST_OFF;
      end
    endcase
    if (s.redo && s.train_on) begin
      next_s.fsm = ST_LOAD;
    end
    if (!s.train_on) begin
      next_s.fsm = ST_OFF;
    end
    next_s.lane_training = (next_s.fsm == ST_LOAD || next_s.fsm == ST_RUN)
                           ? {NUM_LANES{1'b1}} : LANE_RST;

    next_s.tx_ability = s.ability;
    next_s.tx_ctrl = s.ctrl;
    next_s.tx_stat.rx_ready = s.rx_equalizer_done;
    next_s.tx_stat.post_rpt = s.lane0_post_tap_report;
    next_s.tx_stat.main_rpt = s.lane0_main_tap_report;
  end

  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      s.ack <= 1'b0;
      s.rdata <= '0;
      s.ability <= ABILITY_RST;
      s.train_on <= 1'b0;
      s.redo <= 1'b0;
      s.rx_equalizer_done <= LANE_RST;
      s.ctrl <= '{LANE_RST, LANE_RST, COEF_RST, COEF_RST, COEF_RST};
      s.lane0_pattern_seed <= SEED_RST;
      s.lane0_post_tap_report <= COEF_RST;
      s.lane0_main_tap_report <= COEF_RST;
      s.fsm <= ST_OFF;
      s.tx_ability <= ABILITY_RST;
      s.tx_ctrl <= '{LANE_RST, LANE_RST, COEF_RST, COEF_RST, COEF_RST};
      s.tx_stat <= '{LANE_RST, COEF_RST, COEF_RST};
      s.lane_training <= LANE_RST;
    end else begin
      s <= next_s;
    end
  end

  // ******************************************************
  // lane 0 training pattern
  // ******************************************************
  // seed taken at each training start
  alt_pattern_gen #(
    .W(SEED_W)
  ) u_lane0_gen (
    .clk(REF_CLK),
    .rst_n(rst_n),
    .load(s.fsm == ST_LOAD),
    .step(s.fsm == ST_RUN),
    .seed(s.lane0_pattern_seed),
    .pattern_bit(pattern_bit)
  );

  assign WB_DAT_O = s.rdata;
  assign WB_ACK_O = s.ack;
  assign TX_ABILITY = s.tx_ability;
  assign TX_CTRL_BLK = s.tx_ctrl;
  assign TX_STAT_BLK = s.tx_stat;
  assign LANE_TRAINING = s.lane_training;
  assign LANE0_PATTERN = pattern_bit;

  // ******************************************************
  // checks
  // ******************************************************
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!rst_n);

  sequence wr_at(logic [7:0] a);
    WB_CYC_I && WB_STB_I && WB_WE_I && s.ack && WB_ADR_I == a &&
      WB_SEL_I == 4'hf;
  endsequence

  adv_copy_a: assert property (wr_at(ADR_ABILITY) |=> ##1
      TX_ABILITY == $past(WB_DAT_I[NUM_ABILITY-1:0], 2))
    else $error("ability bits not advertised as written");

  mission_mode_a: assert property (!s.train_on |=>
      s.fsm == ST_OFF && LANE_TRAINING == 4'h0)
    else $error("lanes left in training while disabled");

  redo_start_a: assert property (s.redo && s.train_on |=>
      s.fsm == ST_LOAD ##1 s.fsm == ST_RUN || !s.train_on || s.redo)
    else $error("restart did not begin training again");

  preset_copy_a: assert property (wr_at(ADR_LANE_FLAGS) |=> ##1
      TX_CTRL_BLK.preset == $past(WB_DAT_I[FLD_PRESET_LSB +: 4], 2))
    else $error("preset bits not sent as written");

  init_copy_a: assert property (wr_at(ADR_LANE_FLAGS) |=> ##1
      TX_CTRL_BLK.init == $past(WB_DAT_I[FLD_INIT_LSB +: 4], 2))
    else $error("initialize bits not sent as written");

  coef_copy_a: assert property (wr_at(ADR_LANE0_COEF) |=> ##1
      {TX_CTRL_BLK.pre_upd, TX_CTRL_BLK.main_upd, TX_CTRL_BLK.post_upd}
      == $past(WB_DAT_I[5:0], 2))
    else $error("coefficient updates not sent as written");

  report_copy_a: assert property (wr_at(ADR_LANE0_COEF) |=> ##1
      {TX_STAT_BLK.main_rpt, TX_STAT_BLK.post_rpt}
      == $past(WB_DAT_I[9:6], 2))
    else $error("update status not sent as written");

  train_done_a: assert property (s.fsm == ST_RUN &&
      s.rx_equalizer_done == 4'hf && s.train_on && !s.redo |=>
      s.fsm == ST_DONE && LANE_TRAINING == 4'h0)
    else $error("training did not finish when all lanes trained");

  ack_once_a: assert property (WB_CYC_I && WB_STB_I && !s.ack
      |=> s.ack ##1 !s.ack)
    else $error("bus answer not exactly one cycle");

endmodule : alt_an_lt_ctrl
`default_nettype wire

//--- hdl/alt_pattern_gen.sv
`timescale 1ns/1ps
`default_nettype none
module alt_pattern_gen
  import alt_pkg::*;
#(
  parameter int W = SEED_W
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic step,
  input wire logic [W-1:0] seed,
  output logic pattern_bit
);

  typedef struct packed {
    logic [W-1:0] lfsr;
  } alt_gen_s;

  alt_gen_s s;
  alt_gen_s next_s;

  // ******************************************************
  // generator, x^11 + x^9 + 1
  // ******************************************************
  always_comb begin
    next_s = s;
    if (load) begin
      next_s.lfsr = seed;
    end else if (step) begin
      next_s.lfsr = {s.lfsr[W-2:0], s.lfsr[W-1] ^ s.lfsr[W-3]};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s.lfsr <= W'(SEED_RST);
    end else begin
      s <= next_s;
    end
  end

  assign pattern_bit = s.lfsr[W-1];

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  seed_load_a: assert property (load |=> s.lfsr == $past(seed))
    else $error("pattern generator did not take the seed");

endmodule : alt_pattern_gen
`default_nettype wire

//--- hdl/alt_pkg.sv
`default_nettype none
package alt_pkg;

  // ******************************************************
  // bus geometry
  // ******************************************************
  localparam int ADR_W = 8;
  localparam int DAT_W = 32;

  // ******************************************************
  // register offsets (byte addresses, word aligned)
  // ******************************************************
  localparam logic [7:0] ADR_ABILITY = 8'h00;
  localparam logic [7:0] ADR_TRAIN_CTRL = 8'h04;
  localparam logic [7:0] ADR_LANE_FLAGS = 8'h08;
  localparam logic [7:0] ADR_LANE0_SEED = 8'h0c;
  localparam logic [7:0] ADR_LANE0_COEF = 8'h10;
  localparam logic [7:0] ADR_TRAIN_STATUS = 8'h14;

  // ******************************************************
  // field layout
  // ******************************************************
  localparam int NUM_ABILITY = 15;
  localparam int NUM_LANES = 4;
  localparam int SEED_W = 11;
  localparam int ADV_FORTY_FOUR_LANE_BACKPLANE = 3;
  localparam int ADV_TWENTYFIVE_ONE_LANE_BACKPLANE = 11;
  localparam int ADV_FIFTY_TWO_LANE_BACKPLANE = 13;
  localparam int FLD_TRAIN_ON = 0;
  localparam int FLD_TRAIN_REDO = 1;
  localparam int FLD_RX_DONE_LSB = 0;
  localparam int FLD_PRESET_LSB = 4;
  localparam int FLD_INIT_LSB = 8;
  localparam int FLD_POST_UPD_LSB = 0;
  localparam int FLD_MAIN_UPD_LSB = 2;
  localparam int FLD_PRE_UPD_LSB = 4;
  localparam int FLD_POST_RPT_LSB = 6;
  localparam int FLD_MAIN_RPT_LSB = 8;
  localparam int FLD_STATE_LSB = 0;
  localparam int FLD_LANES_LSB = 4;
  localparam int FLD_PATTERN = 8;

  // ******************************************************
  // reset values
  // ******************************************************
  localparam logic [14:0] ABILITY_RST = 15'h0000;
  localparam logic [10:0] SEED_RST = 11'h7ff;
  localparam logic [1:0] COEF_RST = 2'h0;
  localparam logic [3:0] LANE_RST = 4'h0;

  // ******************************************************
  // types
  // ******************************************************
  typedef enum logic [3:0] {
    ST_OFF = 4'b0001,
    ST_LOAD = 4'b0010,
    ST_RUN = 4'b0100,
    ST_DONE = 4'b1000
  } alt_train_e;

  typedef struct packed {
    logic [3:0] preset;
    logic [3:0] init;
    logic [1:0] post_upd;
    logic [1:0] main_upd;
    logic [1:0] pre_upd;
  } alt_ctrl_blk_s;

  typedef struct packed {
    logic [3:0] rx_ready;
    logic [1:0] post_rpt;
    logic [1:0] main_rpt;
  } alt_stat_blk_s;

endpackage : alt_pkg
`default_nettype wire

//--- verification/alt_lp_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// far-end frame receiver
// ****
module alt_lp_model
  import alt_pkg::*;
(
  input wire logic clk,
  input wire logic clr,
  input wire logic [NUM_LANES-1:0] training,
  input wire logic pattern,
  output logic [15:0] ones
);
  // counts pattern ones while lane 0 trains; a stalled generator
  // leaves the count at zero, which is all the far end can tell
  always_ff @(posedge clk) begin
    if (clr) begin
      ones <= 16'h0000;
    end else if (training[0] && pattern) begin
      ones <= ones + 16'h0001;
    end
  end
endmodule : alt_lp_model
`default_nettype wire

//--- verification/alt_tb.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
  import alt_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [ADR_W-1:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [DAT_W-1:0] wdat = 32'h0;
  logic [DAT_W-1:0] rdat;
  logic ack;
  logic [NUM_ABILITY-1:0] ability;
  alt_ctrl_blk_s ctrl;
  alt_stat_blk_s stat;
  logic [NUM_LANES-1:0] lanes;
  logic pat;
  logic clr = 1'b1;
  logic [15:0] ones;
  logic [31:0] rd;
  logic [1:0] b;
  int fails = 0;
  int tests_run = 0;
  int cycles = 0;

  always #4 clk = ~clk;

  alt_an_lt_ctrl uut (
    .REF_CLK(clk), .RST_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat),
    .WB_DAT_O(rdat), .WB_ACK_O(ack), .TX_ABILITY(ability),
    .TX_CTRL_BLK(ctrl), .TX_STAT_BLK(stat), .LANE_TRAINING(lanes),
    .LANE0_PATTERN(pat)
  );

  alt_lp_model lp (
    .clk(clk), .clr(clr), .training(lanes), .pattern(pat), .ones(ones)
  );

  // ****
  // tasks
  // ****
  task final_report;
    if (fails == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : final_report

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask : wt

  // holds the request until ack is seen, then drops for a cycle
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, input logic [3:0] s);
    int n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) begin
      fails++;
      final_report();
    end
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fails++;
      final_report();
    end
  end

  // ****
  // tests
  // ****
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    wt(3);
    check(32'(ability), 32'h0);
    check(32'(lanes), 32'h0);
    check(32'(pat), 32'h1);
    wb(1'b0, ADR_LANE0_SEED, 32'h0, 4'hf);
    check(rd, 32'h7ff);
    wb(1'b0, ADR_TRAIN_STATUS, 32'h0, 4'hf);
    check(rd, 32'h101);
    wb(1'b1, 8'h18, 32'hffffffff, 4'hf);
    wb(1'b0, 8'h18, 32'h0, 4'hf);
    check(rd, 32'h0);
    for (int i = 0; i < NUM_ABILITY; i++) begin
      wb(1'b1, ADR_ABILITY, 32'h1 << i, 4'hf);
      wt(3);
      check(32'(ability), 32'h1 << i);
    end
    // the three backplane abilities at their codeword positions
    wb(1'b1, ADR_ABILITY, (32'h1 << ADV_FORTY_FOUR_LANE_BACKPLANE)
       | (32'h1 << ADV_TWENTYFIVE_ONE_LANE_BACKPLANE)
       | (32'h1 << ADV_FIFTY_TWO_LANE_BACKPLANE), 4'hf);
    wt(3);
    check(32'(ability), 32'h2808);
    // only the low byte lane is enabled
    wb(1'b1, ADR_ABILITY, 32'hffffffff, 4'h1);
    wt(3);
    check(32'(ability), 32'h28ff);
    wb(1'b0, ADR_ABILITY, 32'h0, 4'hf);
    check(rd, 32'h28ff);
    for (int i = 0; i < NUM_LANES; i++) begin
      wb(1'b1, ADR_LANE_FLAGS, (32'h10 << i) | (32'h800 >> i)
         | (32'h1 << i), 4'hf);
      wt(3);
      check(32'(ctrl.preset), 32'h1 << i);
      check(32'(ctrl.init), 32'h8 >> i);
      check(32'(stat.rx_ready), 32'h1 << i);
    end
    wb(1'b0, ADR_LANE_FLAGS, 32'h0, 4'hf);
    check(rd, 32'h188);
    for (int v = 0; v < 4; v++) begin
      b = 2'(v);
      wb(1'b1, ADR_LANE0_COEF,
         {22'h0, ~b, b ^ 2'h3, b ^ 2'h2, b ^ 2'h1, b}, 4'hf);
      wt(3);
      check(32'(ctrl.post_upd), 32'(b));
      check(32'(ctrl.main_upd), 32'(b ^ 2'h1));
      check(32'(ctrl.pre_upd), 32'(b ^ 2'h2));
      check(32'(stat.post_rpt), 32'(b ^ 2'h3));
      check(32'(stat.main_rpt), {30'h0, ~b});
    end
    wb(1'b0, ADR_LANE0_COEF, 32'h0, 4'hf);
    check(rd, 32'h1b);
    // a zero seed stalls the generator, so the far end sees no ones
    wb(1'b1, ADR_LANE_FLAGS, 32'h0, 4'hf);
    wb(1'b1, ADR_LANE0_SEED, 32'h0, 4'hf);
    wb(1'b1, ADR_TRAIN_CTRL, 32'h1, 4'hf);
    wt(4);
    check(32'(lanes), 32'hf);
    clr <= 1'b0;
    wt(20);
    check(32'(ones), 32'h0);
    wb(1'b0, ADR_TRAIN_STATUS, 32'h0, 4'hf);
    check({24'h0, rd[7:0]}, 32'hf4);
    clr <= 1'b1;
    wb(1'b1, ADR_LANE0_SEED, 32'h5a5, 4'hf);
    wb(1'b1, ADR_TRAIN_CTRL, 32'h3, 4'hf);
    wb(1'b0, ADR_TRAIN_CTRL, 32'h0, 4'hf);
    check(rd, 32'h1);
    clr <= 1'b0;
    wt(30);
    check(32'(ones != 16'h0), 32'h1);
    // control logic reports every receiver equalizer settled
    wb(1'b1, ADR_LANE_FLAGS, 32'hf, 4'hf);
    wt(4);
    check(32'(lanes), 32'h0);
    wb(1'b0, ADR_TRAIN_STATUS, 32'h0, 4'hf);
    check({28'h0, rd[3:0]}, 32'h8);
    wb(1'b1, ADR_LANE_FLAGS, 32'h0, 4'hf);
    wb(1'b1, ADR_TRAIN_CTRL, 32'h3, 4'hf);
    wt(4);
    check(32'(lanes), 32'hf);
    wb(1'b1, ADR_TRAIN_CTRL, 32'h0, 4'hf);
    wt(3);
    check(32'(lanes), 32'h0);
    wb(1'b1, ADR_TRAIN_STATUS, 32'hffffffff, 4'hf);
    wb(1'b0, ADR_TRAIN_STATUS, 32'h0, 4'hf);
    check({24'h0, rd[7:0]}, 32'h01);
    final_report();
  end
endmodule : testbench
`default_nettype wire
